// [verilog/uart_ctl_cfg.svh]
// Constants for the serial line control block
`ifndef UART_CTL_CFG_SVH
`define UART_CTL_CFG_SVH
`define UC_OFS_FIFO 5'h00
`define UC_OFS_FMT 5'h04
`define UC_OFS_MODEM 5'h08
`define UC_OFS_EFC 5'h0C
`define UC_OFS_STAT 5'h10
`define UC_RST_REG 8'h00
`define UC_FC_EN 0
`define UC_FC_RXCLR 1
`define UC_FC_TXCLR 2
`define UC_FC_MODE 3
`define UC_FC_TXT 5:4
`define UC_FC_RXT 7:6
`define UC_LF_LEN 1:0
`define UC_LF_STB 2
`define UC_LF_PEN 3
`define UC_LF_PAR 5:4
`define UC_LF_BRK 6
`define UC_LF_DAS 7
`define UC_MC_DTR 0
`define UC_MC_RTS 1
`define UC_MC_OUT1 2
`define UC_MC_OUT2 3
`define UC_MC_LOOP 4
`define UC_MC_OSRC 5
`define UC_MC_IR 6
`define UC_MC_PRE 7
`define UC_MC_ENH_MASK 8'hE0
`define UC_FC_ENH_MASK 8'h30
`define UC_EF_ENH 4
`define UC_EF_RTSFC 6
`define UC_TXT_00 6'h10
`define UC_TXT_01 6'h08
`define UC_TXT_10 6'h18
`define UC_TXT_11 6'h1E
`define UC_TXT_EMPTY 6'h01
`define UC_RXT_00 6'h08
`define UC_RXT_01 6'h10
`define UC_RXT_10 6'h18
`define UC_RXT_11 6'h1C
`define UC_LEN_BASE 4'h5
`define UC_PRE_LAST 2'h3
`define UC_IR_PULSE 4'h3
`define UC_IR_BIT 4'hF
`define UC_FIFO_DEPTH 32
`endif

// [verilog/uart_ctl_pkg.sv]
// Types shared by the serial line control block
package uart_ctl_pkg;
   typedef enum logic [1:0] {
      PAR_ODD = 2'b00,
      PAR_EVEN = 2'b01,
      PAR_MARK = 2'b10,
      PAR_SPACE = 2'b11
   } parity_t;
   typedef struct packed {
      logic [3:0] data_bits;
      logic one_half_stop;
      logic two_stop;
      logic par_en;
      parity_t par;
      logic brk;
   } char_format_t;
   typedef struct packed {
      logic cts;
      logic dsr;
      logic ri;
      logic cd;
   } modem_lines_t;
endpackage

// [verilog/uart_ctl.sv]
// FIFO, character format and modem line control with Wishbone registers
`timescale 1ns/1ps
`include "uart_ctl_cfg.svh"
`default_nettype none
module uart_ctl #(
   parameter int DEPTH = `UC_FIFO_DEPTH,
   parameter int CW = $clog2(DEPTH + 1)
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Transceiver core side
   input wire logic rx_push_i,
   input wire logic rx_pop_i,
   input wire logic tx_push_i,
   input wire logic tx_pop_i,
   input wire logic ser_tx_i,
   input wire logic baud16_tick_i,
   input wire logic irq_src_i,
   output logic [CW-1:0] rx_count_o,
   output logic [CW-1:0] tx_count_o,
   output logic fifo_en_o,
   output logic rx_trig_hit_o,
   output logic tx_below_trig_o,
   output logic ser_rx_o,
   output uart_ctl_pkg::char_format_t fmt_o,
   output uart_ctl_pkg::modem_lines_t modem_st_o,
   output logic divisor_access_o,
   output logic baud_clk_en_o,
   // Pins
   input wire logic rx_pin_i,
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic ri_n_i,
   input wire logic cd_n_i,
   input wire logic pc_mode_i,
   output logic tx_pin_o,
   output logic dtr_n_o,
   output logic rts_n_o,
   output logic user_output_one_n_o,
   output logic user_output_two_n_o,
   output logic rx_ready_pin_n_o,
   output logic tx_ready_pin_n_o,
   output logic irq_o,
   output logic irq_oe_n_o
);
   logic [7:0] fifo_ctl_ff;
   logic [7:0] fmt_ctl_ff;
   logic [7:0] modem_ctl_ff;
   logic [7:0] efc_ff;
   logic rx_clr_ff;
   logic tx_clr_ff;
   logic [5:0] pin_s1_ff;
   logic [5:0] pin_s2_ff;
   logic [CW-1:0] cnt_ff [2];
   logic [1:0] push;
   logic [1:0] pop;
   logic [1:0] clr;
   logic [CW-1:0] cap;
   logic enh;
   logic [7:0] fc_eff;
   logic [7:0] mc_eff;
   logic [5:0] rx_trig;
   logic [5:0] tx_trig;
   logic acc;
   logic wr;
   logic [31:0] nxt_dat;
   logic rx_rdy_n_ff;
   logic [1:0] pre_ff;
   logic tx_prev_ff;
   logic [3:0] enc_ff;
   logic [3:0] dec_ff;
   logic tx_data;
   logic rx_sync;
   logic ir_rx;

   // Trigger decoding, shared by receive and transmit thresholds
   function automatic logic [5:0] trig_level(input logic [1:0] code,
         input logic is_tx);
      logic [5:0] lvl;
      lvl = `UC_RXT_00;
      unique case (code)
         2'h0: lvl = is_tx ? `UC_TXT_00 : `UC_RXT_00;
         2'h1: lvl = is_tx ? `UC_TXT_01 : `UC_RXT_01;
         2'h2: lvl = is_tx ? `UC_TXT_10 : `UC_RXT_10;
         2'h3: lvl = is_tx ? `UC_TXT_11 : `UC_RXT_11;
      endcase
      return lvl;
   endfunction

   // Effective control after enhanced gating
   assign enh = efc_ff[`UC_EF_ENH];
   assign fc_eff = enh ? fifo_ctl_ff : (fifo_ctl_ff & ~`UC_FC_ENH_MASK);
   assign mc_eff = enh ? modem_ctl_ff : (modem_ctl_ff & ~`UC_MC_ENH_MASK);
   assign rx_trig = trig_level(fc_eff[`UC_FC_RXT], 1'b0);
   // Without enhanced mode the transmit event means empty
   assign tx_trig = enh ? trig_level(fc_eff[`UC_FC_TXT], 1'b1) :
      `UC_TXT_EMPTY;
   assign cap = fc_eff[`UC_FC_EN] ? CW'(DEPTH) : CW'(1);
   // Bus decode
   assign acc = cyc_i && stb_i && !ack_o;
   assign wr = acc && we_i && sel_i[0];
   // Pin synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_ff <= 6'h3F;
         pin_s2_ff <= 6'h3F;
      end else if (ce_i) begin
         pin_s1_ff <= {pc_mode_i, rx_pin_i, cts_n_i, dsr_n_i, ri_n_i, cd_n_i};
         pin_s2_ff <= pin_s1_ff;
      end
   end
   // Wishbone acknowledge, one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= acc;
      end
   end
   // Read data mux
   always_comb begin
      nxt_dat = 32'h0000_0000;
      unique case (adr_i)
         `UC_OFS_FIFO: nxt_dat[7:0] = fifo_ctl_ff;
         `UC_OFS_FMT: nxt_dat[7:0] = fmt_ctl_ff;
         `UC_OFS_MODEM: nxt_dat[7:0] = modem_ctl_ff;
         `UC_OFS_EFC: nxt_dat[7:0] = fmt_ctl_ff[`UC_LF_DAS] ? efc_ff : 8'h00;
         `UC_OFS_STAT: begin
            nxt_dat[CW-1:0] = cnt_ff[0];
            nxt_dat[8+CW-1:8] = cnt_ff[1];
            nxt_dat[16] = rx_ready_pin_n_o;
            nxt_dat[17] = tx_ready_pin_n_o;
         end
         default: nxt_dat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (ce_i && acc) begin
         dat_o <= we_i ? 32'h0000_0000 : nxt_dat;
      end
   end
   // FIFO control register; clear bits are pulses, never stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fifo_ctl_ff <= `UC_RST_REG;
         rx_clr_ff <= 1'b0;
         tx_clr_ff <= 1'b0;
      end else if (ce_i) begin
         rx_clr_ff <= 1'b0;
         tx_clr_ff <= 1'b0;
         if (wr && adr_i == `UC_OFS_FIFO) begin
            fifo_ctl_ff[`UC_FC_EN] <= dat_i[`UC_FC_EN];
            fifo_ctl_ff[`UC_FC_MODE] <= dat_i[`UC_FC_MODE];
            fifo_ctl_ff[`UC_FC_RXT] <= dat_i[`UC_FC_RXT];
            if (enh) begin
               fifo_ctl_ff[`UC_FC_TXT] <= dat_i[`UC_FC_TXT];
            end
            rx_clr_ff <= dat_i[`UC_FC_RXCLR] ||
               (dat_i[`UC_FC_EN] != fifo_ctl_ff[`UC_FC_EN]);
            tx_clr_ff <= dat_i[`UC_FC_TXCLR] ||
               (dat_i[`UC_FC_EN] != fifo_ctl_ff[`UC_FC_EN]);
         end
      end
   end
   // Line format register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fmt_ctl_ff <= `UC_RST_REG;
      end else if (ce_i && wr && adr_i == `UC_OFS_FMT) begin
         fmt_ctl_ff <= dat_i[7:0];
      end
   end
   // Enhanced feature register, reachable only with divisor access set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         efc_ff <= `UC_RST_REG;
      end else if (ce_i && wr && adr_i == `UC_OFS_EFC &&
            fmt_ctl_ff[`UC_LF_DAS]) begin
         efc_ff <= dat_i[7:0];
      end
   end
   // Modem control register; flow control owns the request bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         modem_ctl_ff <= `UC_RST_REG;
      end else if (ce_i) begin
         if (wr && adr_i == `UC_OFS_MODEM) begin
            modem_ctl_ff[4:0] <= dat_i[4:0];
            if (enh) begin
               modem_ctl_ff[7:5] <= dat_i[7:5];
            end
         end
         if (enh && efc_ff[`UC_EF_RTSFC]) begin
            modem_ctl_ff[`UC_MC_RTS] <= !(cnt_ff[0] >= CW'(rx_trig));
         end
      end
   end

   // Occupancy counters: index 0 receive, index 1 transmit
   assign push = {tx_push_i, rx_push_i};
   assign pop = {tx_pop_i, rx_pop_i};
   assign clr = {tx_clr_ff, rx_clr_ff};
   generate
      for (genvar i = 0; i < 2; i++) begin : g_cnt
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               cnt_ff[i] <= '0;
            end else if (ce_i) begin
               if (clr[i]) begin
                  cnt_ff[i] <= '0;
               end else begin
                  unique case ({push[i] && cnt_ff[i] < cap,
                        pop[i] && cnt_ff[i] != '0})
                     2'b10: cnt_ff[i] <= cnt_ff[i] + CW'(1);
                     2'b01: cnt_ff[i] <= cnt_ff[i] - CW'(1);
                     default: cnt_ff[i] <= cnt_ff[i];
                  endcase
               end
            end
         end
      end
   endgenerate
   // Count and threshold outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_count_o <= '0;
         tx_count_o <= '0;
         rx_trig_hit_o <= 1'b0;
         tx_below_trig_o <= 1'b1;
         fifo_en_o <= 1'b0;
      end else if (ce_i) begin
         rx_count_o <= cnt_ff[0];
         tx_count_o <= cnt_ff[1];
         rx_trig_hit_o <= cnt_ff[0] >= CW'(rx_trig);
         tx_below_trig_o <= cnt_ff[1] < CW'(tx_trig);
         fifo_en_o <= fc_eff[`UC_FC_EN];
      end
   end

   // Ready pins, active low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_ready_pin_n_o <= 1'b0;
         rx_rdy_n_ff <= 1'b1;
      end else if (ce_i) begin
         if (fc_eff[`UC_FC_EN] && fc_eff[`UC_FC_MODE]) begin
            tx_ready_pin_n_o <= cnt_ff[1] == cap;
            if (cnt_ff[0] == '0) begin
               rx_rdy_n_ff <= 1'b1;
            end else if (cnt_ff[0] >= CW'(rx_trig)) begin
               rx_rdy_n_ff <= 1'b0;
            end
         end else begin
            tx_ready_pin_n_o <= cnt_ff[1] != '0;
            rx_rdy_n_ff <= cnt_ff[0] == '0;
         end
      end
   end
   assign rx_ready_pin_n_o = rx_rdy_n_ff;
   // Character format to the transceiver core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fmt_o <= '0;
         divisor_access_o <= 1'b0;
      end else if (ce_i) begin
         fmt_o.data_bits <= `UC_LEN_BASE + {2'h0, fmt_ctl_ff[`UC_LF_LEN]};
         fmt_o.one_half_stop <= fmt_ctl_ff[`UC_LF_STB] &&
            fmt_ctl_ff[`UC_LF_LEN] == 2'h0;
         fmt_o.two_stop <= fmt_ctl_ff[`UC_LF_STB] &&
            fmt_ctl_ff[`UC_LF_LEN] != 2'h0;
         fmt_o.par_en <= fmt_ctl_ff[`UC_LF_PEN];
         fmt_o.par <= uart_ctl_pkg::parity_t'(fmt_ctl_ff[`UC_LF_PAR]);
         fmt_o.brk <= fmt_ctl_ff[`UC_LF_BRK];
         divisor_access_o <= fmt_ctl_ff[`UC_LF_DAS];
      end
   end
   // Clock prescaler ahead of the baud generator
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_ff <= 2'h0;
         baud_clk_en_o <= 1'b0;
      end else if (ce_i) begin
         pre_ff <= pre_ff + 2'h1;
         baud_clk_en_o <= !mc_eff[`UC_MC_PRE] || pre_ff == `UC_PRE_LAST;
      end
   end

   // Infrared encoder: short high pulse at the start of each zero bit
   assign tx_data = ser_tx_i && !fmt_ctl_ff[`UC_LF_BRK];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enc_ff <= 4'h0;
         tx_prev_ff <= 1'b1;
      end else if (ce_i) begin
         tx_prev_ff <= tx_data;
         if (tx_data || tx_prev_ff) begin
            enc_ff <= 4'h0;
         end else if (baud16_tick_i) begin
            enc_ff <= enc_ff + 4'h1;
         end
      end
   end

   // Infrared decoder: a pulse stretches to one zero bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dec_ff <= 4'h0;
      end else if (ce_i) begin
         if (pin_s2_ff[4]) begin
            dec_ff <= `UC_IR_BIT;
         end else if (baud16_tick_i && dec_ff != 4'h0) begin
            dec_ff <= dec_ff - 4'h1;
         end
      end
   end
   assign ir_rx = !pin_s2_ff[4] && dec_ff == 4'h0;
   assign rx_sync = mc_eff[`UC_MC_IR] ? ir_rx : pin_s2_ff[4];

   // Serial pins and loop-back routing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_pin_o <= 1'b1;
         ser_rx_o <= 1'b1;
      end else if (ce_i) begin
         if (modem_ctl_ff[`UC_MC_LOOP]) begin
            tx_pin_o <= 1'b1;
            ser_rx_o <= tx_data;
         end else begin
            ser_rx_o <= rx_sync;
            if (mc_eff[`UC_MC_IR]) begin
               tx_pin_o <= !tx_data && !tx_prev_ff &&
                  enc_ff < `UC_IR_PULSE;
            end else begin
               tx_pin_o <= tx_data;
            end
         end
      end
   end

   // Modem outputs and the modem line state seen by the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dtr_n_o <= 1'b1;
         rts_n_o <= 1'b1;
         user_output_one_n_o <= 1'b1;
         user_output_two_n_o <= 1'b1;
         modem_st_o <= '0;
      end else if (ce_i) begin
         if (modem_ctl_ff[`UC_MC_LOOP]) begin
            dtr_n_o <= 1'b1;
            rts_n_o <= 1'b1;
            user_output_one_n_o <= 1'b1;
            user_output_two_n_o <= 1'b1;
            modem_st_o.cts <= modem_ctl_ff[`UC_MC_RTS];
            modem_st_o.dsr <= modem_ctl_ff[`UC_MC_DTR];
            modem_st_o.ri <= modem_ctl_ff[`UC_MC_OUT1];
            modem_st_o.cd <= modem_ctl_ff[`UC_MC_OUT2];
         end else begin
            dtr_n_o <= !modem_ctl_ff[`UC_MC_DTR];
            rts_n_o <= !modem_ctl_ff[`UC_MC_RTS];
            user_output_one_n_o <= !modem_ctl_ff[`UC_MC_OUT1];
            user_output_two_n_o <= !modem_ctl_ff[`UC_MC_OUT2];
            modem_st_o <= ~pin_s2_ff[3:0];
         end
      end
   end

   // Interrupt pin drive; enable is low while driving
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         irq_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         irq_o <= irq_src_i;
         if (pin_s2_ff[5] && !modem_ctl_ff[`UC_MC_OUT2]) begin
            irq_oe_n_o <= 1'b1;
         end else if (mc_eff[`UC_MC_OSRC]) begin
            irq_oe_n_o <= !irq_src_i;
         end else begin
            irq_oe_n_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/uart_ctl_checker.sv]
// Assertions on the serial control block outputs
`timescale 1ns/1ps
`default_nettype none
module uart_ctl_checker #(
   parameter int DEPTH = 32,
   parameter int CW = 6
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched outputs
   input wire logic [CW-1:0] rx_count_o,
   input wire logic [CW-1:0] tx_count_o,
   input wire logic fifo_en_o,
   input wire logic rx_trig_hit_o,
   input wire logic tx_below_trig_o,
   input wire uart_ctl_pkg::char_format_t fmt_o,
   input wire logic rx_ready_pin_n_o,
   input wire logic tx_ready_pin_n_o
);
   // All checks share the block clock and reset
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_char_mode_cap: assert property (
      !fifo_en_o [*4] |-> rx_count_o <= 1 && tx_count_o <= 1)
      else $error("count above one without FIFOs");
   a_mode0_tx_pin: assert property (
      !fifo_en_o [*4] |-> tx_ready_pin_n_o == (tx_count_o != 0))
      else $error("tx ready pin wrong in mode 0");
   a_mode0_rx_pin: assert property (
      !fifo_en_o [*4] |-> rx_ready_pin_n_o == (rx_count_o == 0))
      else $error("rx ready pin wrong in mode 0");
   a_tx_empty_below: assert property (
      tx_count_o == 0 && $past(tx_count_o) == 0 |-> tx_below_trig_o)
      else $error("empty tx FIFO not below trigger");
   a_rx_under_trig: assert property (
      rx_count_o < 8 && $stable(rx_count_o) |-> !rx_trig_hit_o)
      else $error("rx trigger hit below eight");
   a_rx_top_hit: assert property (
      rx_count_o >= 28 && $stable(rx_count_o) |-> rx_trig_hit_o)
      else $error("rx trigger missed at 28");
   a_fifo_depth_bound: assert property (
      rx_count_o <= DEPTH && tx_count_o <= DEPTH)
      else $error("FIFO count above depth");
   a_half_stop_five: assert property (
      fmt_o.one_half_stop |-> fmt_o.data_bits == 4'h5 && !fmt_o.two_stop)
      else $error("half stop with wrong length");
   a_two_stop_long: assert property (
      fmt_o.two_stop |-> fmt_o.data_bits != 4'h5)
      else $error("two stop bits on five bit word");
endmodule
bind uart_ctl uart_ctl_checker #(.DEPTH(DEPTH), .CW(CW)) i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .rx_count_o(rx_count_o),
   .tx_count_o(tx_count_o), .fifo_en_o(fifo_en_o), .fmt_o(fmt_o),
   .rx_trig_hit_o(rx_trig_hit_o), .tx_below_trig_o(tx_below_trig_o),
   .rx_ready_pin_n_o(rx_ready_pin_n_o), .tx_ready_pin_n_o(tx_ready_pin_n_o)
);
`default_nettype wire

// [tb/modem_line_model.sv]
// Far-end peer on the serial and modem pins, wired as a null modem
`timescale 1ns/1ps
`default_nettype none
module modem_line_model (
   // Pins driven by the device
   input wire logic clk_i,
   input wire logic tx_pin_i,
   input wire logic dtr_n_i,
   input wire logic rts_n_i,
   // Pins into the device
   output logic rx_pin_o,
   output logic cts_n_o,
   output logic dsr_n_o,
   output logic ri_n_o,
   output logic cd_n_o
);
   // Cable turns data and handshakes round after one cycle
   always_ff @(posedge clk_i) begin
      rx_pin_o <= tx_pin_i;
      cts_n_o <= rts_n_i;
      dsr_n_o <= dtr_n_i;
   end
   // No ringing; carrier present
   assign ri_n_o = 1'b1;
   assign cd_n_o = 1'b0;
endmodule
`default_nettype wire

// [tb/uart_fifo_line_modem_control_test.sv]
// Register, FIFO and pin tests for the serial control block
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_line_modem_control_test;
   // Stimulus
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] dat = 32'h0;
   logic [3:0] ev = 4'h0;
   logic ser_tx = 1'b1;
   logic tick = 1'b0;
   logic irq_src = 1'b0;
   logic pc = 1'b0;
   // Design outputs and peer pins
   logic [31:0] dat_o;
   logic [5:0] rxc, txc;
   logic ack, fen, rxhit, txbelow, ser_rx, das, bce, tx_pin, irq, irq_oe_n;
   logic dtr_n, rts_n, out1_n, out2_n, rxr_n, txr_n;
   logic rx_pin, cts_n, dsr_n, ri_n, cd_n;
   uart_ctl_pkg::char_format_t fmt;
   uart_ctl_pkg::modem_lines_t mst;
   // Bench state
   logic [31:0] rd;
   logic [31:0] cnt;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int rxt[4] = '{8, 16, 24, 28};
   uart_ctl i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(cyc),
      .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(dat_o),
      .ack_o(ack), .rx_push_i(ev[0]), .rx_pop_i(ev[1]), .tx_push_i(ev[2]),
      .tx_pop_i(ev[3]), .ser_tx_i(ser_tx), .baud16_tick_i(tick),
      .irq_src_i(irq_src), .rx_count_o(rxc), .tx_count_o(txc),
      .fifo_en_o(fen), .rx_trig_hit_o(rxhit), .tx_below_trig_o(txbelow),
      .ser_rx_o(ser_rx), .fmt_o(fmt), .modem_st_o(mst),
      .divisor_access_o(das), .baud_clk_en_o(bce), .rx_pin_i(rx_pin),
      .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .cd_n_i(cd_n),
      .pc_mode_i(pc), .tx_pin_o(tx_pin), .dtr_n_o(dtr_n), .rts_n_o(rts_n),
      .user_output_one_n_o(out1_n), .user_output_two_n_o(out2_n),
      .rx_ready_pin_n_o(rxr_n), .tx_ready_pin_n_o(txr_n), .irq_o(irq),
      .irq_oe_n_o(irq_oe_n)
   );
   modem_line_model i_peer (
      .clk_i(clk_i), .tx_pin_i(tx_pin), .dtr_n_i(dtr_n), .rts_n_i(rts_n),
      .rx_pin_o(rx_pin), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n),
      .cd_n_o(cd_n)
   );
   // Clock
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // Baud tick and hang guard
   always @(posedge clk_i) begin
      tick <= ~tick;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         final_report();
      end
   end
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Classic bus cycle; read data lands in rd
   task automatic wb(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= wr;
      adr <= a;
      dat <= {24'h0, d};
      @(posedge clk_i);
      // Ends on ack; if ack never comes only the bench watchdog ends it
      while (ack !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = dat_o;
      cyc <= 1'b0;
      we <= 1'b0;
      w(2);
   endtask
   // Pulse core FIFO strobes, then let counts settle
   task automatic ops(input logic [3:0] m, input int n);
      repeat (n) begin
         @(posedge clk_i);
         ev <= m;
         @(posedge clk_i);
         ev <= 4'h0;
      end
      w(3);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   // Counts, verdict, end of run
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Test sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      w(4);
      chk({txr_n, rxr_n, dtr_n, rts_n, out1_n, out2_n}, 6'h1F);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, 5'h04, 8'(4 + i));
         chk(fmt.data_bits, 5 + i);
         chk({fmt.one_half_stop, fmt.two_stop}, (i == 0) ? 2 : 1);
         wb(1'b1, 5'h04, 8'(8 + 16 * i));
         chk({fmt.par_en, fmt.par}, 4 + i);
      end
      wb(1'b1, 5'h04, 8'h40);
      chk(tx_pin, 0);
      wb(1'b1, 5'h04, 8'h00);
      chk(tx_pin, 1);
      done("format");
      wb(1'b1, 5'h0C, 8'h50);
      wb(1'b0, 5'h0C, 8'h00);
      chk(rd, 0);
      wb(1'b1, 5'h04, 8'h80);
      chk(das, 1);
      wb(1'b1, 5'h0C, 8'h50);
      wb(1'b0, 5'h0C, 8'h00);
      chk(rd, 8'h50);
      wb(1'b0, 5'h14, 8'h00);
      chk(rd, 0);
      wb(1'b1, 5'h04, 8'h00);
      done("divisor");
      wb(1'b1, 5'h00, 8'h01);
      wb(1'b1, 5'h00, 8'h31);
      chk({fen, rts_n}, 2'b10);
      ops(4'h1, 8);
      chk({rxhit, rts_n, rxr_n}, 3'b110);
      wb(1'b0, 5'h08, 8'h00);
      chk(rd[1], 0);
      ops(4'h4, 29);
      chk(txbelow, 1);
      ops(4'h4, 4);
      chk({txc, txbelow}, {6'd32, 1'b0});
      wb(1'b1, 5'h00, 8'h39);
      chk(txr_n, 1);
      ops(4'h8, 12);
      chk({txr_n, txbelow}, 2'b01);
      wb(1'b1, 5'h04, 8'h80);
      wb(1'b1, 5'h0C, 8'h00);
      wb(1'b1, 5'h04, 8'h00);
      chk(txbelow, 0);
      wb(1'b1, 5'h00, 8'h3D);
      chk({txc, rxc}, {6'd0, 6'd8});
      wb(1'b0, 5'h00, 8'h00);
      chk(rd[2:1], 0);
      for (int t = 0; t < 4; t++) begin
         wb(1'b1, 5'h00, {t[1:0], 6'h0B});
         ops(4'h1, rxt[t] - 1);
         chk({rxhit, rxr_n}, 2'b01);
         ops(4'h1, 1);
         chk({rxhit, rxr_n}, 2'b10);
         ops(4'h2, rxt[t] - 1);
         chk(rxr_n, 0);
         ops(4'h2, 1);
         chk(rxr_n, 1);
      end
      wb(1'b1, 5'h00, 8'h00);
      ops(4'h5, 2);
      chk({txc, rxc}, {6'd1, 6'd1});
      chk({txr_n, rxr_n}, 2'b10);
      wb(1'b0, 5'h10, 8'h00);
      chk(rd, 32'h0002_0101);
      done("fifo");
      wb(1'b1, 5'h08, 8'h05);
      w(4);
      chk({dtr_n, rts_n, out1_n, out2_n, mst}, 8'h55);
      wb(1'b1, 5'h08, 8'h15);
      ser_tx <= 1'b0;
      w(4);
      chk({dtr_n, rts_n, out1_n, out2_n, mst}, 8'hF6);
      chk({tx_pin, ser_rx}, 2'b10);
      ser_tx <= 1'b1;
      pc <= 1'b1;
      wb(1'b1, 5'h08, 8'h00);
      w(3);
      chk(irq_oe_n, 1);
      wb(1'b1, 5'h08, 8'h08);
      chk(irq_oe_n, 0);
      pc <= 1'b0;
      wb(1'b1, 5'h04, 8'h80);
      wb(1'b1, 5'h0C, 8'h10);
      wb(1'b1, 5'h04, 8'h00);
      wb(1'b1, 5'h08, 8'h20);
      chk({irq, irq_oe_n}, 2'b01);
      irq_src <= 1'b1;
      w(3);
      chk({irq, irq_oe_n}, 2'b10);
      for (int p = 0; p < 2; p++) begin
         wb(1'b1, 5'h08, p ? 8'h00 : 8'h80);
         cnt = 0;
         repeat (40) begin
            @(posedge clk_i);
            cnt = cnt + 32'(bce);
         end
         chk(cnt, p ? 40 : 10);
      end
      wb(1'b1, 5'h08, 8'h40);
      w(3);
      chk(tx_pin, 0);
      // A zero bit gives a short pulse that the peer loops back
      ser_tx <= 1'b0;
      w(3);
      chk(tx_pin, 1);
      w(8);
      chk(ser_rx, 0);
      ser_tx <= 1'b1;
      w(48);
      chk(ser_rx, 1);
      done("modem");
      final_report();
   end
endmodule
`default_nettype wire
